/* rtl/record_path.sv */
// stereo record path: decimation, high-pass, gain stepping, AGC, AHB-Lite registers
`timescale 1ns/100ps
module record_path
  import record_path_pkg::*;
#(
  parameter int AVG_SHIFT = 5
) (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic MOD_L,
  input wire logic MOD_R,
  output logic [15:0] PCM_L,
  output logic [15:0] PCM_R,
  output logic PCM_VALID,
  output logic [6:0] PGA_GAIN_L,
  output logic [6:0] PGA_GAIN_R,
  output logic ADC_ON_L,
  output logic ADC_ON_R,
  output logic RECORD_ROUTE
);
  if (AVG_SHIFT < 1 || AVG_SHIFT > 12) begin : g_bad_shift
    $error("AVG_SHIFT out of range");
  end

  localparam int STAGES = GROUP_DELAY - 1;

  typedef struct packed {
    logic [255:0][7:0] regs;
    logic ahb_wr;
    logic [7:0] ahb_idx;
    logic [31:0] hrdata;
    logic [1:0][1:0] sync;
    logic [3:0] mod_cnt;
    logic [6:0] tick_cnt;
    logic [1:0][7:0] ones;
    logic [1:0][STAGES-1:0][15:0] delay;
    logic [1:0][15:0] hxp, hyp, fxp, fyp, pcm;
    logic pcm_valid;
    logic [1:0][6:0] applied, agc_gain;
    logic [1:0] step_odd, noise;
    logic [1:0][15:0] avg, att_cnt, dec_cnt;
    logic [1:0][2:0] deb_cnt;
  } state_s;

  state_s s, next;
  logic sample, route, soft_off;
  logic [3:0] div_code;
  logic [1:0] on, reached, pwr_req;
  logic [1:0][6:0] prog, want, ceiling;
  logic [1:0][15:0] x;

  function automatic logic signed [15:0] to_pcm(input logic [7:0] ones, input logic dual);
    logic signed [17:0] v;
    v = dual ? ($signed({10'h000, ones}) - 18'sh00020) * 18'sh00400
             : ($signed({10'h000, ones}) - 18'sh00040) * 18'sh00200;
    // all-ones window lands one code past full scale
    if (v > 18'sh07FFF) return 16'sh7FFF;
    return v[15:0];
  endfunction : to_pcm

  function automatic logic signed [15:0] filt(input logic signed [15:0] n0, n1, d1,
                                              input logic signed [15:0] xn, xp, yp);
    logic signed [33:0] acc;
    // widen before multiplying so the products keep all 32 bits
    acc = 34'(n0) * 34'(xn) + 34'(n1) * 34'(xp) + 34'(d1) * 34'(yp);
    acc = acc >>> 15;
    if (acc > 34'sh000007FFF) return 16'sh7FFF;
    if (acc < 34'sh3FFFF8000) return 16'sh8000;
    return acc[15:0];
  endfunction : filt

  function automatic logic [15:0] coef(input logic [255:0][7:0] r, input logic [7:0] idx);
    return {r[idx], r[8'(idx + 8'h01)]};
  endfunction : coef

  function automatic logic [6:0] level_of(input logic [7:0] code);
    return (code[6:0] > GAIN_CODE_MAX) ? LEVEL_TOP : 7'(code[6:0] + 7'h01);
  endfunction : level_of

  // noise threshold: -30 dB at code 1, about 2 dB lower per code
  function automatic logic [15:0] noise_thr(input logic [4:0] code);
    logic [4:0] sh;
    sh = 5'(5'h05 + (code - 5'h01) / 5'h03);
    return 16'h7FFF >> sh;
  endfunction : noise_thr

  function automatic logic mapped(input logic [7:0] idx);
    return idx == IDX_HPF_ENABLE || idx == IDX_GAIN_L || idx == IDX_GAIN_R
        || (idx >= IDX_CLK_CTRL && idx <= IDX_DAC_PWR)
        || (idx >= IDX_ATT_R && idx <= IDX_FILT_SEL)
        || (idx >= IDX_FX_LO && idx <= IDX_FX_HI)
        || (idx >= IDX_HPF_COEF_L && idx <= IDX_HPF_LAST);
  endfunction : mapped

  assign soft_off = s.regs[IDX_PWR_CTRL][PWR_SOFT_OFF];
  assign route = s.regs[IDX_DAC_PWR][7:6] == 2'h0 && s.regs[IDX_FILT_SEL][FILT_ROUTE];

  always_comb begin
    logic [7:0] aidx, rd;
    logic [7:0] sum;
    logic [6:0] last;
    logic signed [15:0] d, h, f, n0, n1, d1, hmag;
    logic signed [17:0] diff;
    logic [15:0] thr, tgt, att_lim, dec_lim;
    logic quiet, loud, flip;
    aidx = HADDR[9:2];
    rd = 8'h00;
    sum = 8'h00;
    d = '0;
    h = '0;
    f = '0;
    n0 = '0;
    n1 = '0;
    d1 = '0;
    hmag = '0;
    diff = '0;
    thr = '0;
    tgt = '0;
    att_lim = '0;
    dec_lim = '0;
    quiet = 1'b0;
    loud = 1'b0;
    flip = 1'b0;
    sample = 1'b0;
    x = '0;
    next = s;
    next.pcm_valid = 1'b0;
    next.sync = {s.sync[1][0], MOD_R, s.sync[0][0], MOD_L};
    div_code = (s.regs[IDX_CLK_CTRL][3:0] > DIV_CODE_MAX) ? DIV_CODE_MAX
                                                          : s.regs[IDX_CLK_CTRL][3:0];
    for (int c = 0; c < 2; c++) begin
      pwr_req[c] = s.regs[IDX_PWR_CTRL][c];
      prog[c] = level_of(s.regs[IDX_GAIN[c]]);
      ceiling[c] = level_of(s.regs[IDX_MAXG[c]]);
      on[c] = pwr_req[c] || s.applied[c] != LEVEL_MUTE;
      reached[c] = s.applied[c] == prog[c];
      if (!pwr_req[c]) want[c] = LEVEL_MUTE;
      else if (s.regs[IDX_AGC[c]][AGC_ENABLE]) want[c] = s.agc_gain[c];
      else want[c] = prog[c];
    end
    // bus: zero wait states, write lands at the end of its data phase
    next.ahb_wr = 1'b0;
    if (HSEL && HTRANS[1] && HREADY) begin
      next.ahb_wr = HWRITE && HADDR[31:10] == 22'h000000 && mapped(aidx);
      next.ahb_idx = aidx;
      if (!HWRITE) begin
        if (HADDR[31:10] != 22'h000000) rd = 8'h00;
        else if (aidx == IDX_STATUS)
          rd = {1'b0, route, s.noise, on, reached};
        else if (aidx == IDX_APPLIED_L) rd = {1'b0, s.applied[0]};
        else if (aidx == IDX_APPLIED_R) rd = {1'b0, s.applied[1]};
        else if (mapped(aidx)) rd = s.regs[aidx];
        next.hrdata = {24'h000000, rd};
      end
    end
    if (s.ahb_wr && s.ahb_idx != IDX_STATUS && s.ahb_idx != IDX_APPLIED_L
        && s.ahb_idx != IDX_APPLIED_R)
      next.regs[s.ahb_idx] = HWDATA[7:0];
    // decimator: one modulator bit per div_code+2 clocks, 128 (64 dual) bits per sample
    last = s.regs[IDX_CLK_CTRL][CLK_DUAL] ? OSR_DUAL_LAST : OSR_SINGLE_LAST;
    next.mod_cnt = 4'(s.mod_cnt + 4'h1);
    if (s.mod_cnt >= 4'(div_code + 4'h1)) begin
      next.mod_cnt = 4'h0;
      next.tick_cnt = 7'(s.tick_cnt + 7'h01);
      if (s.tick_cnt >= last) begin
        next.tick_cnt = 7'h00;
        sample = 1'b1;
      end
      for (int c = 0; c < 2; c++) begin
        sum = 8'(s.ones[c] + {7'h00, s.sync[c][1]});
        next.ones[c] = sample ? 8'h00 : sum;
        x[c] = to_pcm(sum, s.regs[IDX_CLK_CTRL][CLK_DUAL]);
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (sample) begin
        // shift line plus output flop gives the fixed latency
        d = s.delay[c][STAGES-1];
        next.delay[c] = {s.delay[c][STAGES-2:0], x[c]};
        if (s.regs[IDX_FILT_SEL][7-c]) begin
          n0 = coef(s.regs, IDX_HPF_COEF[c]);
          n1 = coef(s.regs, 8'(IDX_HPF_COEF[c] + 8'h02));
          d1 = coef(s.regs, 8'(IDX_HPF_COEF[c] + 8'h04));
        end else begin
          d1 = hpf_d1(s.regs[IDX_HPF_ENABLE][7-2*c -: 2]);
          n0 = 16'(({1'b0, d1} + 17'h08000) >> 1);
          n1 = -n0;
        end
        h = (s.regs[IDX_HPF_ENABLE][7-2*c -: 2] != 2'h0) ? filt(n0, n1, d1, d, s.hxp[c], s.hyp[c]) : d;
        next.hxp[c] = d;
        next.hyp[c] = h;
        f = h;
        if (route) begin
          f = filt(coef(s.regs, IDX_FX_COEF[c]), coef(s.regs, 8'(IDX_FX_COEF[c] + 8'h02)),
                   coef(s.regs, 8'(IDX_FX_COEF[c] + 8'h04)), h, s.fxp[c], s.fyp[c]);
        end
        next.fxp[c] = h;
        next.fyp[c] = f;
        next.pcm[c] = on[c] ? f : 16'h0000;
        next.pcm_valid = 1'b1;
        next.step_odd[c] = ~s.step_odd[c];
        // agc works on samples, so its timing follows the divider
        hmag = h[15] ? -h : h;
        if (h == 16'sh8000) hmag = 16'sh7FFF;
        diff = $signed({2'b00, hmag}) - $signed({2'b00, s.avg[c]});
        next.avg[c] = 16'($signed({2'b00, s.avg[c]}) + (diff >>> AVG_SHIFT));
        thr = noise_thr(s.regs[IDX_NOISE[c]][4:0]);
        quiet = s.regs[IDX_NOISE[c]][4:0] != 5'h00 && s.avg[c] < thr;
        loud = s.regs[IDX_NOISE[c]][4:0] == 5'h00 || s.avg[c] > {thr[14:0], 1'b0};
        flip = s.noise[c] ? loud : quiet;
        next.deb_cnt[c] = 3'h0;
        if (s.regs[IDX_NOISE[c]][4:0] == 5'h00) next.noise[c] = 1'b0;
        else if (flip && s.deb_cnt[c] >= s.regs[IDX_NOISE[c]][7:5]) next.noise[c] = ~s.noise[c];
        else if (flip) next.deb_cnt[c] = 3'(s.deb_cnt[c] + 3'h1);
        tgt = agc_target(s.regs[IDX_AGC[c]][6:4]);
        att_lim = 16'((16'(s.regs[IDX_ATT[c]]) + 16'h0001) * ATTACK_UNIT);
        dec_lim = 16'((16'(s.regs[IDX_DEC[c]]) + 16'h0001) * DECAY_UNIT);
        if (s.noise[c]) begin
          next.att_cnt[c] = 16'h0000;
          next.dec_cnt[c] = 16'h0000;
          if (s.agc_gain[c] > LEVEL_0DB) next.agc_gain[c] = 7'(s.agc_gain[c] - 7'h01);
        end else if (s.agc_gain[c] > ceiling[c]) begin
          next.agc_gain[c] = 7'(s.agc_gain[c] - 7'h01);
        end else if (s.avg[c] > tgt) begin
          next.dec_cnt[c] = 16'h0000;
          next.att_cnt[c] = 16'(s.att_cnt[c] + 16'h0001);
          if (s.att_cnt[c] >= att_lim) begin
            next.att_cnt[c] = 16'h0000;
            if (s.agc_gain[c] > LEVEL_0DB) next.agc_gain[c] = 7'(s.agc_gain[c] - 7'h01);
          end
        end else if (s.avg[c] < tgt) begin
          next.att_cnt[c] = 16'h0000;
          // counter holds at 0xFFFF so it cannot wrap; the decay register sets the longest decay
          if (s.dec_cnt[c] != 16'hFFFF) next.dec_cnt[c] = 16'(s.dec_cnt[c] + 16'h0001);
          if (s.dec_cnt[c] >= dec_lim && s.agc_gain[c] < ceiling[c]) begin
            next.dec_cnt[c] = 16'h0000;
            next.agc_gain[c] = 7'(s.agc_gain[c] + 7'h01);
          end
        end
      end
      // applied gain walks one level at a time unless stepping is off
      if (soft_off) next.applied[c] = want[c];
      else if (sample && (!s.regs[IDX_PWR_CTRL][PWR_TWO_STEP] || s.step_odd[c])) begin
        if (s.applied[c] < want[c]) next.applied[c] = 7'(s.applied[c] + 7'h01);
        else if (s.applied[c] > want[c]) next.applied[c] = 7'(s.applied[c] - 7'h01);
      end
    end
    if (!RST_N) begin
      next = '0;
      next.applied = {LEVEL_MUTE, LEVEL_MUTE};
      next.agc_gain = {LEVEL_0DB, LEVEL_0DB};
      next.regs = {256{RST_REG}};
    end
  end

  always_ff @(posedge MCLK) begin
    s <= next;
  end

  assign HRDATA = s.hrdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign PCM_L = s.pcm[0];
  assign PCM_R = s.pcm[1];
  assign PCM_VALID = s.pcm_valid;
  assign PGA_GAIN_L = s.applied[0];
  assign PGA_GAIN_R = s.applied[1];
  assign ADC_ON_L = on[0];
  assign ADC_ON_R = on[1];
  assign RECORD_ROUTE = route;

  // cycles since the last sample, for the spacing check
  logic [8:0] gap;
  always_ff @(posedge MCLK) begin
    if (!RST_N || PCM_VALID) gap <= RST_N ? 9'h000 : 9'h1FF;
    else if (gap != 9'h1FF) gap <= 9'(gap + 9'h001);
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  sequence s_power_dropped;
    $fell(ADC_ON_L);
  endsequence

  sequence s_step_taken;
    !$past(soft_off) ##0 $changed(PGA_GAIN_L);
  endsequence

  a_sample_spacing: assert property (PCM_VALID |-> gap >= 9'd127)
    else $error("samples closer than the shortest output period");
  a_gain_one_step: assert property (s_step_taken |->
      PGA_GAIN_L == 7'($past(PGA_GAIN_L) + 7'h01)
      || PGA_GAIN_L == 7'($past(PGA_GAIN_L) - 7'h01))
    else $error("gain moved more than one step");
  a_direct_settle: assert property (soft_off && $stable(want[0]) |=> PGA_GAIN_L == $past(want[0]))
    else $error("gain did not jump with stepping off");
  a_mute_reset: assert property ($rose(RST_N) |-> PGA_GAIN_L == LEVEL_MUTE
      && PGA_GAIN_R == LEVEL_MUTE)
    else $error("gain not muted after reset");
  a_shutdown_mute: assert property (s_power_dropped |-> PGA_GAIN_L == LEVEL_MUTE
      && ($past(soft_off) || $past(PGA_GAIN_L) <= LEVEL_0DB))
    else $error("channel shut down before reaching mute");
  a_gain_range: assert property (PGA_GAIN_L <= LEVEL_TOP && PGA_GAIN_R <= LEVEL_TOP)
    else $error("gain above 59.5 dB");
  a_noise_ramp: assert property (sample && s.noise[0] && s.agc_gain[0] > LEVEL_0DB
      |=> s.agc_gain[0] == 7'($past(s.agc_gain[0]) - 7'h01))
    else $error("noise gate did not ramp toward 0 dB");
  a_off_silent: assert property (sample && !on[0] |=> PCM_VALID && PCM_L == 16'h0000)
    else $error("powered-down channel produced data");
endmodule : record_path

/* rtl/record_path_pkg.sv */
// constants, register map and helpers for the stereo record path
// Functional notes
// - decimate 128 Fs stream, fixed 17-sample delay
// - 8-48 kHz single rate, 96 kHz dual
// - each channel powered on its own
// - gain 0 to 59.5 dB, 0.5 dB steps
// - soft step per 1 or 2 samples, disableable
// - reset muted; power-down steps to mute first
// - flag when applied gain equals programmed gain
// - high-pass y=(N0x+N1xp+D1yp)/32768, 16-bit coefficients
// - left coefficients 65-70, right 71-76, page 1
// - custom select 107[7:6], enable 12[7:4]
// - effects route when DACs off and 107[3]
// - independent gain controller per channel, absolute average
// - eight targets from -5.5 to -24 dB
// - attack 7 ms to 1408 ms, extended registers
// - decay 0.05 s to 22.4 s, extended registers
// - decay limit from fixed counter length; here the decay register sets it and the counter only saturates
// - noise ramps gain to 0 dB, flag set
// - noise threshold -30 to -90 dB, debounce, hysteresis
// - controller gain ceiling 0 to 59.5 dB
// - time constants count reference-rate samples only; here every output sample counts, so timing follows the divider
// - rate is reference over divider 1 to 6
package record_path_pkg;
  // register indexes; byte address is four times the index, page 1 sits at 0x80 up
  localparam logic [7:0] IDX_HPF_ENABLE = 8'h0C;
  localparam logic [7:0] IDX_GAIN_L = 8'h13;
  localparam logic [7:0] IDX_GAIN_R = 8'h16;
  localparam logic [7:0] IDX_CLK_CTRL = 8'h1A;
  localparam logic [7:0] IDX_PWR_CTRL = 8'h1B;
  localparam logic [7:0] IDX_AGC_L = 8'h1C;
  localparam logic [7:0] IDX_NOISE_L = 8'h1D;
  localparam logic [7:0] IDX_MAXG_L = 8'h1E;
  localparam logic [7:0] IDX_AGC_R = 8'h1F;
  localparam logic [7:0] IDX_NOISE_R = 8'h20;
  localparam logic [7:0] IDX_MAXG_R = 8'h21;
  localparam logic [7:0] IDX_STATUS = 8'h22;
  localparam logic [7:0] IDX_APPLIED_L = 8'h23;
  localparam logic [7:0] IDX_APPLIED_R = 8'h24;
  localparam logic [7:0] IDX_DAC_PWR = 8'h25;
  localparam logic [7:0] IDX_ATT_R = 8'h67;
  localparam logic [7:0] IDX_DEC_R = 8'h68;
  localparam logic [7:0] IDX_ATT_L = 8'h69;
  localparam logic [7:0] IDX_DEC_L = 8'h6A;
  localparam logic [7:0] IDX_FILT_SEL = 8'h6B;
  localparam logic [7:0] IDX_FX_LO = 8'h81;
  localparam logic [7:0] IDX_FX_HI = 8'hB4;
  localparam logic [7:0] IDX_FX_COEF_L = 8'h95;
  localparam logic [7:0] IDX_FX_COEF_R = 8'hAF;
  localparam logic [7:0] IDX_HPF_COEF_L = 8'hC1;
  localparam logic [7:0] IDX_HPF_COEF_R = 8'hC7;
  localparam logic [7:0] IDX_HPF_LAST = 8'hCC;
  localparam logic [7:0] IDX_GAIN [2] = '{IDX_GAIN_L, IDX_GAIN_R};
  localparam logic [7:0] IDX_AGC [2] = '{IDX_AGC_L, IDX_AGC_R};
  localparam logic [7:0] IDX_NOISE [2] = '{IDX_NOISE_L, IDX_NOISE_R};
  localparam logic [7:0] IDX_MAXG [2] = '{IDX_MAXG_L, IDX_MAXG_R};
  localparam logic [7:0] IDX_ATT [2] = '{IDX_ATT_L, IDX_ATT_R};
  localparam logic [7:0] IDX_DEC [2] = '{IDX_DEC_L, IDX_DEC_R};
  localparam logic [7:0] IDX_HPF_COEF [2] = '{IDX_HPF_COEF_L, IDX_HPF_COEF_R};
  localparam logic [7:0] IDX_FX_COEF [2] = '{IDX_FX_COEF_L, IDX_FX_COEF_R};
  // field positions
  localparam int PWR_SOFT_OFF = 2;
  localparam int PWR_TWO_STEP = 3;
  localparam int CLK_DUAL = 4;
  localparam int AGC_ENABLE = 7;
  localparam int FILT_ROUTE = 3;
  localparam logic [7:0] RST_REG = 8'h00;
  // gain levels: 0 is mute, level k is (k-1)*0.5 dB
  localparam logic [6:0] LEVEL_MUTE = 7'h00;
  localparam logic [6:0] LEVEL_0DB = 7'h01;
  localparam logic [6:0] GAIN_CODE_MAX = 7'h77;
  localparam logic [6:0] LEVEL_TOP = 7'h78;
  localparam logic [3:0] DIV_CODE_MAX = 4'hA;
  localparam logic [6:0] OSR_SINGLE_LAST = 7'h7F;
  localparam logic [6:0] OSR_DUAL_LAST = 7'h3F;
  localparam int GROUP_DELAY = 17;
  localparam logic [15:0] ATTACK_UNIT = 16'h0003;
  localparam logic [15:0] DECAY_UNIT = 16'h0014;

  function automatic logic [15:0] agc_target(input logic [2:0] code);
    unique case (code)
      3'h0: return 16'h440B;
      3'h1: return 16'h32F5;
      3'h2: return 16'h287A;
      3'h3: return 16'h2027;
      3'h4: return 16'h198A;
      3'h5: return 16'h1215;
      3'h6: return 16'h0CCD;
      3'h7: return 16'h0814;
    endcase
  endfunction : agc_target

  // built-in dc blocker poles, one per corner setting
  function automatic logic [15:0] hpf_d1(input logic [1:0] sel);
    unique case (sel)
      2'h1: return 16'h7F00;
      2'h2: return 16'h7E00;
      default: return 16'h7C00;
    endcase
  endfunction : hpf_d1
endpackage : record_path_pkg

/* test/mod_source.sv */
// modulator bit stream source standing in for the analog front end
`timescale 1ns/100ps
module mod_source (
  input wire logic clk,
  output logic mod_l,
  output logic mod_r
);
  logic [3:0] phase = 4'h0;
  initial begin
    mod_l = 1'b0;
    mod_r = 1'b1;
  end
  // left mostly ones, right toggles: distinct levels per channel
  always @(posedge clk) begin
    phase <= phase + 4'h1;
    mod_l <= (phase != 4'h3);
    mod_r <= phase[0];
  end
endmodule : mod_source

/* test/record_path_tb.sv */
// self-checking bench for the stereo record path
`timescale 1ns/100ps
module record_path_tb;
  import record_path_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hresp, mod_l, mod_r, pcm_valid, on_l, on_r, route;
  logic [15:0] pcm_l, pcm_r;
  logic [6:0] gain_l, gain_r, prev_l, prev_r;
  logic watch_step = 1'b0;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] rw_idx [17] = '{IDX_HPF_ENABLE, IDX_GAIN_L, IDX_GAIN_R, IDX_CLK_CTRL, IDX_AGC_L,
    IDX_NOISE_R, IDX_MAXG_L, IDX_DAC_PWR, IDX_ATT_R, IDX_DEC_R, IDX_ATT_L, IDX_DEC_L,
    IDX_FILT_SEL, IDX_FX_LO, IDX_FX_HI, IDX_HPF_COEF_L, IDX_HPF_LAST};

  always #10 mclk = ~mclk;

  record_path u_record_path (.MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .MOD_L(mod_l), .MOD_R(mod_r),
    .PCM_L(pcm_l), .PCM_R(pcm_r), .PCM_VALID(pcm_valid), .PGA_GAIN_L(gain_l),
    .PGA_GAIN_R(gain_r), .ADC_ON_L(on_l), .ADC_ON_R(on_r), .RECORD_ROUTE(route));
  mod_source u_mod_source (.clk(mclk), .mod_l(mod_l), .mod_r(mod_r));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val

  // cut a hang short well above the expected run length
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors = num_errors + 1;
      give_verdict();
    end
  end

  function automatic logic one_step(input logic [6:0] a, input logic [6:0] b);
    return (a > b) ? (a - b == 7'h01) : (b - a == 7'h01);
  endfunction : one_step

  always @(posedge mclk) begin
    prev_l <= gain_l;
    prev_r <= gain_r;
    if (watch_step && gain_l !== prev_l)
      check_val({31'h0, one_step(gain_l, prev_l)}, 32'h1);
    if (watch_step && gain_r !== prev_r)
      check_val({31'h0, one_step(gain_r, prev_r)}, 32'h1);
  end

  function automatic logic [31:0] ra(input logic [7:0] idx);
    return {22'h0, idx, 2'h0};
  endfunction : ra

  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge mclk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge mclk);
      n++;
    end
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge mclk);
    while (hready !== 1'b1 && n < 100) begin
      @(posedge mclk);
      n++;
    end
    rd = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, ra(idx), {24'hFFFFFF, d}, x);
  endtask : wr

  task automatic rd(input logic [7:0] idx, output logic [31:0] x);
    xfer(1'b0, ra(idx), 32'h0, x);
  endtask : rd

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] x;
    rd(idx, x);
    check_val(x, {24'h0, exp});
  endtask : rd_chk

  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  task automatic in_range(input int v, input int lo, input int hi);
    check_val({31'h0, v >= lo && v <= hi}, 32'h1);
  endtask : in_range

  // counts sample pulses until the applied gain reaches the level
  task automatic wait_gain(input logic ch, input logic [6:0] lvl, output int pulses);
    int n;
    pulses = 0;
    for (n = 0; n < 8000; n++) begin
      @(posedge mclk);
      if (pcm_valid === 1'b1)
        pulses++;
      if ((ch ? gain_r : gain_l) === lvl)
        break;
    end
    check_val({25'h0, ch ? gain_r : gain_l}, {25'h0, lvl});
  endtask : wait_gain

  task automatic t_regs;
    logic [31:0] x;
    check_val({25'h0, on_l, on_r, route, hready, hresp, 2'h0}, 32'h8);
    check_val({18'h0, gain_l, gain_r}, 32'h0);
    foreach (rw_idx[i])
      rd_chk(rw_idx[i], 8'h00);
    wr(IDX_STATUS, 8'hFF);
    wr(IDX_APPLIED_L, 8'h55);
    wr(8'h50, 8'h77);
    xfer(1'b1, 32'h400 | ra(IDX_GAIN_L), 32'h33, x);
    rd_chk(IDX_STATUS, 8'h00);
    rd_chk(IDX_APPLIED_L, 8'h00);
    rd_chk(8'h50, 8'h00);
    rd_chk(IDX_GAIN_L, 8'h00);
    foreach (rw_idx[i])
      wr(rw_idx[i], rw_idx[i] ^ 8'h5A);
    foreach (rw_idx[i])
      rd_chk(rw_idx[i], rw_idx[i] ^ 8'h5A);
    foreach (rw_idx[i])
      wr(rw_idx[i], 8'h00);
    $display("test registers done");
  endtask : t_regs

  task automatic t_step;
    logic [31:0] x;
    int n;
    watch_step = 1'b1;
    wr(IDX_GAIN_L, 8'h04);
    wr(IDX_PWR_CTRL, 8'h01);
    #1;
    check_val({30'h0, on_l, on_r}, 32'h2);
    rd(IDX_STATUS, x);
    check_val(x & 32'h5, 32'h4);
    wait_gain(1'b0, 7'h05, n);
    in_range(n, 4, 6);
    rd(IDX_STATUS, x);
    check_val(x & 32'h5, 32'h5);
    rd_chk(IDX_APPLIED_L, 8'h05);
    wr(IDX_PWR_CTRL, 8'h09);
    wr(IDX_GAIN_L, 8'h00);
    wait_gain(1'b0, 7'h01, n);
    in_range(n, 6, 9);
    // power-down ramps to mute while the clock keeps running
    wr(IDX_PWR_CTRL, 8'h01);
    wr(IDX_GAIN_L, 8'h03);
    wait_gain(1'b0, 7'h04, n);
    wr(IDX_PWR_CTRL, 8'h00);
    #1;
    check_val({31'h0, on_l}, 32'h1);
    wait_gain(1'b0, 7'h00, n);
    in_range(n, 3, 5);
    settle();
    check_val({31'h0, on_l}, 32'h0);
    watch_step = 1'b0;
    $display("test soft step done");
  endtask : t_step

  task automatic t_no_step;
    logic [7:0] codes [4] = '{8'h00, 8'h76, 8'h77, 8'h7F};
    logic [6:0] lvls [4] = '{7'h01, 7'h77, 7'h78, 7'h78};
    wr(IDX_PWR_CTRL, 8'h05);
    foreach (codes[i]) begin
      wr(IDX_GAIN_L, codes[i]);
      settle();
      check_val({25'h0, gain_l}, {25'h0, lvls[i]});
    end
    wr(IDX_PWR_CTRL, 8'h06);
    wr(IDX_GAIN_R, 8'h0A);
    settle();
    check_val({16'h0, gain_l, on_l, gain_r, on_r}, {16'h0, 8'h00, 7'h0B, 1'b1});
    rd_chk(IDX_APPLIED_R, 8'h0B);
    wr(IDX_PWR_CTRL, 8'h04);
    settle();
    check_val({30'h0, on_l, on_r}, 32'h0);
    $display("test direct gain done");
  endtask : t_no_step

  task automatic t_route;
    logic [7:0] dac [6] = '{8'h00, 8'hC0, 8'h40, 8'h80, 8'h00, 8'h00};
    logic [7:0] sel [6] = '{8'h08, 8'h08, 8'h08, 8'h08, 8'h00, 8'hF7};
    logic exp [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    logic [31:0] x;
    foreach (dac[i]) begin
      wr(IDX_DAC_PWR, dac[i]);
      wr(IDX_FILT_SEL, sel[i]);
      rd(IDX_STATUS, x);
      check_val({30'h0, route, x[6]}, {30'h0, exp[i], exp[i]});
    end
    wr(IDX_FILT_SEL, 8'h00);
    $display("test record route done");
  endtask : t_route

  task automatic period(output int p, output logic w);
    int n;
    for (n = 0; n < 5000 && pcm_valid !== 1'b1; n++)
      @(posedge mclk);
    p = 0;
    do begin
      @(posedge mclk);
      p++;
      if (p == 1)
        w = pcm_valid;
    end while (pcm_valid !== 1'b1 && p < 5000);
  endtask : period

  // stride-2 sampling of the source gives one of two fixed level pairs
  task automatic t_pcm;
    int p;
    logic w;
    wr(IDX_PWR_CTRL, 8'h07);
    repeat (24) period(p, w);
    #1;
    check_val({31'h0, (pcm_l == 16'h6000 && pcm_r == 16'h7FFF)
      || (pcm_l == 16'h7FFF && pcm_r == 16'h8000)}, 32'h1);
    wr(IDX_PWR_CTRL, 8'h04);
    $display("test sample data done");
  endtask : t_pcm

  task automatic t_rate;
    logic [7:0] clk_code [5] = '{8'h00, 8'h01, 8'h0A, 8'h10, 8'h1A};
    int span [5] = '{256, 384, 1536, 128, 768};
    int p;
    logic w;
    wr(IDX_PWR_CTRL, 8'h05);
    foreach (clk_code[i]) begin
      wr(IDX_CLK_CTRL, clk_code[i]);
      period(p, w);
      period(p, w);
      check_val(p, span[i]);
      check_val({31'h0, w}, 32'h0);
    end
    wr(IDX_CLK_CTRL, 8'h00);
    wr(IDX_PWR_CTRL, 8'h04);
    $display("test sample rate done");
  endtask : t_rate

  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    #1;
    t_regs();
    t_step();
    t_no_step();
    t_route();
    t_pcm();
    t_rate();
    give_verdict();
  end
endmodule : record_path_tb
